/* File: design/lrs_pkg.sv */
/*
 Constants, field layouts and scan state encoding for the LCD row-scan driver core.
 Assumes one 250 MHz system clock; every slow pin is sampled by that clock.
*/
// Contract
// - Internal clock runs at 32x frame rate: frame is 4 x 8 internal ticks.
// - Frame sync toggles once per frame, so its period covers two frames.
// - External clock enters on oscillator input; feedback and clock output left open.
// - Both chip id inputs low selects master; any other code selects slave.
// - Up to four chips with distinct ids share a panel, all synced to master.
// - Panel sync pin is driven in master mode and followed in slave mode.
// - Each shift clock rising edge shifts one serial data bit into the register.
// - Latch is transparent while high and holds the last value once low.
// - Word select high means address word, low means segment word.
// - Blank forces segments off and stops display reads; RAM writes still accepted.
// - Blank falling: sync within 2 ticks, row pointer to 0, row 1 one eighth later.
// - Power-on reset holds commons and segments in static light-out regardless of blank.
// - Reset release: sync within 2 ticks, scanning restarts at row 0, blank still honoured.
// - Segment is select level for RAM bit 1, non-select for bit 0.
// - Display RAM is 8 rows of 64 bits; row follows common scan.
// - Master clock output feeds slave oscillator inputs; sync pins tied together.
// - Address word: row in bits 3..1, id match in 5..4, bit 0 high.
// - Address sent LSB first; first segment bit shifted lands on segment 63.
// - Row address precedes segment data; serial input ignored during power-on reset.
package lrs_pkg;
   localparam int ROWS          = 8;
   localparam int SEG_W         = 64;
   localparam int ADDR_W        = 8;
   localparam int ROW_W         = 3;
   localparam int ID_W          = 2;
   localparam int TICKS_PER_ROW = 4;
   localparam int TICK_W        = 2;
   localparam int SYNC_MAX_TICKS = 2;
   // Address word fields
   localparam int ADDR_DUMMY_BIT = 0;
   localparam int ADDR_ROW_LSB   = 1;
   localparam int ADDR_ROW_MSB   = 3;
   localparam int ADDR_ID_LSB    = 4;
   localparam int ADDR_ID_MSB    = 5;
   localparam logic [ID_W-1:0]   MASTER_ID     = 2'h0;
   localparam logic [TICK_W-1:0] TICK_LAST     = 2'h3;
   localparam logic [ROW_W-1:0]  ROW_FIRST     = 3'h0;
   localparam logic [ROW_W-1:0]  ROW_RST       = 3'h0;
   localparam logic [TICK_W-1:0] TICK_RST      = 2'h0;
   localparam logic [SEG_W-1:0]  SEG_RST       = 64'h0000_0000_0000_0000;
   localparam logic [ROWS-1:0]   COM_RST       = 8'h00;

   typedef enum logic [2:0] {
      SC_HALT = 3'b001,
      SC_ARM  = 3'b010,
      SC_RUN  = 3'b100
   } lrs_scan_t;
endpackage : lrs_pkg

/* File: design/lrs_row_scan.sv */
/*
 LCD row-scan driver core: serial loader, 8x64 display RAM, row scanner, panel sync.
 Assumes all pins are asynchronous to clk and much slower than it; the internal
 display clock arrives on the oscillator input and is edge-detected here.
*/
`timescale 1ns/1ps
module lrs_row_scan (
   input  wire logic                      clk,          // 250 MHz system clock
   input  wire logic                      srst,         // Synchronous reset, high
   input  wire logic                      ce,           // Clock enable, freezes state when low
   input  wire logic                      oscillator_input, // Internal display clock pin
   input  wire logic                      chip_id_bit0, // Chip identity strap bit 0
   input  wire logic                      chip_id_bit1, // Chip identity strap bit 1
   input  wire logic                      shiftClk,     // Serial shift clock pin
   input  wire logic                      serData,      // Serial data pin
   input  wire logic                      latchIn,      // Level latch pin
   input  wire logic                      wordSel,      // High address word, low segment word
   input  wire logic                      display_blank, // Blank pin, high blanks
   input  wire logic                      porIn,        // Power-on reset pin, high holds
   input  wire logic                      panelSyncIn,  // Panel sync pin, input side
   output logic                           panelSyncOut, // Panel sync pin, output side
   output logic                           panelSyncOe,  // Panel sync drive enable
   output logic                           clockOut,     // Internal clock copy for slaves
   output logic                           isMaster,     // Master mode indication
   output logic [lrs_pkg::ROWS-1:0]       common_outputs, // One-hot selected common
   output logic [lrs_pkg::SEG_W-1:0]      segment_outputs, // 1 select, 0 non-select
   output logic                           staticOff     // Static light-out during reset
);

   function automatic logic [lrs_pkg::ADDR_W-1:0] rev8(input logic [lrs_pkg::ADDR_W-1:0] v);
      logic [lrs_pkg::ADDR_W-1:0] r;
      r = '0;
      for (int i = 0; i < lrs_pkg::ADDR_W; i++)
      begin
         r[i] = v[lrs_pkg::ADDR_W-1-i];
      end
      return r;
   endfunction : rev8

   function automatic logic [lrs_pkg::ROWS-1:0] rowDecode(input logic [lrs_pkg::ROW_W-1:0] row);
      logic [lrs_pkg::ROWS-1:0] d;
      d = '0;
      d[row] = 1'b1;
      return d;
   endfunction : rowDecode

   // Two-flop synchronisers; the third stage feeds edge detectors only
   logic [2:0] oscSync_r;
   logic [2:0] sckSync_r;
   logic [2:0] blankSync_r;
   logic [2:0] porSync_r;
   logic [2:0] frmSync_r;
   logic [1:0] datSync_r;
   logic [1:0] latSync_r;
   logic [1:0] selSync_r;
   logic [1:0] id0Sync_r;
   logic [1:0] id1Sync_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         // Pulled-up pins reset high so no false edge follows reset
         oscSync_r   <= 3'h0;
         sckSync_r   <= 3'h7;
         blankSync_r <= 3'h7;
         porSync_r   <= 3'h7;
         frmSync_r   <= 3'h0;
         datSync_r   <= 2'h0;
         latSync_r   <= 2'h0;
         selSync_r   <= 2'h0;
         id0Sync_r   <= 2'h0;
         id1Sync_r   <= 2'h0;
      end
      else if (ce)
      begin
         oscSync_r   <= {oscSync_r[1:0], oscillator_input};
         sckSync_r   <= {sckSync_r[1:0], shiftClk};
         blankSync_r <= {blankSync_r[1:0], display_blank};
         porSync_r   <= {porSync_r[1:0], porIn};
         frmSync_r   <= {frmSync_r[1:0], panelSyncIn};
         datSync_r   <= {datSync_r[0], serData};
         latSync_r   <= {latSync_r[0], latchIn};
         selSync_r   <= {selSync_r[0], wordSel};
         id0Sync_r   <= {id0Sync_r[0], chip_id_bit0};
         id1Sync_r   <= {id1Sync_r[0], chip_id_bit1};
      end
   end

   logic                      tick;
   logic                      sckRise;
   logic                      blankFall;
   logic                      porFall;
   logic                      frmEdge;
   logic                      blankLvl;
   logic                      porLvl;
   logic [lrs_pkg::ID_W-1:0]  chipId;
   logic                      master;

   assign tick      = oscSync_r[1] & ~oscSync_r[2];
   assign sckRise   = sckSync_r[1] & ~sckSync_r[2];
   assign blankFall = ~blankSync_r[1] & blankSync_r[2];
   assign porFall   = ~porSync_r[1] & porSync_r[2];
   assign frmEdge   = frmSync_r[1] ^ frmSync_r[2];
   assign blankLvl  = blankSync_r[1];
   assign porLvl    = porSync_r[1];
   assign chipId    = {id1Sync_r[1], id0Sync_r[1]};
   assign master    = (chipId == lrs_pkg::MASTER_ID);

   // Serial shift register; new bits enter at bit 0
   logic [lrs_pkg::SEG_W-1:0] shift_r;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         shift_r <= lrs_pkg::SEG_RST;
      end
      else if (ce && sckRise && !porLvl)
      begin
         shift_r <= {shift_r[lrs_pkg::SEG_W-2:0], datSync_r[1]};
      end
   end

   // Address word arrives LSB first, so the last eight bits are reversed
   logic [lrs_pkg::ADDR_W-1:0] addrWord;
   logic                       addrMatch;

   assign addrWord  = rev8(shift_r[lrs_pkg::ADDR_W-1:0]);
   assign addrMatch = (addrWord[lrs_pkg::ADDR_ID_MSB:lrs_pkg::ADDR_ID_LSB] == chipId);

   logic [lrs_pkg::ROW_W-1:0] rowAddr_r;
   logic                      addrMine_r;
   logic                      latchOpen;

   // Latch passes data while high; once low, the values held are simply not updated
   assign latchOpen = latSync_r[1] & ~porLvl;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         rowAddr_r  <= lrs_pkg::ROW_RST;
         addrMine_r <= 1'b0;
      end
      else if (ce && latchOpen && selSync_r[1])
      begin
         addrMine_r <= addrMatch;
         if (addrMatch)
         begin
            rowAddr_r <= addrWord[lrs_pkg::ADDR_ROW_MSB:lrs_pkg::ADDR_ROW_LSB];
         end
      end
   end

   // Display RAM; contents are undefined to the user until written
   logic [lrs_pkg::SEG_W-1:0] ram_r [lrs_pkg::ROWS];

   always_ff @(posedge clk)
   begin
      if (ce && latchOpen && !selSync_r[1] && addrMine_r)
      begin
         ram_r[rowAddr_r] <= shift_r;
      end
   end

   // Scan sequencer
   lrs_pkg::lrs_scan_t        scan_r;
   logic [lrs_pkg::TICK_W-1:0] tickCnt_r;
   logic [lrs_pkg::ROW_W-1:0]  row_r;
   logic                      syncTgl_r;
   logic                      restart;
   logic                      rowEnd;

   // Master restarts on the next internal tick, i.e. within two ticks of the event
   // A slave has no restart of its own; it waits for the master's sync edge
   assign restart = master ? tick : frmEdge;
   assign rowEnd  = (tickCnt_r == lrs_pkg::TICK_LAST);

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         scan_r    <= lrs_pkg::SC_HALT;
         tickCnt_r <= lrs_pkg::TICK_RST;
         row_r     <= lrs_pkg::ROW_RST;
         syncTgl_r <= 1'b0;
      end
      else if (ce)
      begin
         case (scan_r)
            lrs_pkg::SC_HALT:
            begin
               tickCnt_r <= lrs_pkg::TICK_RST;
               row_r     <= lrs_pkg::ROW_RST;
               if (porFall || !porLvl)
               begin
                  scan_r <= lrs_pkg::SC_ARM;
               end
            end
            lrs_pkg::SC_ARM:
            begin
               if (porLvl)
               begin
                  scan_r <= lrs_pkg::SC_HALT;
               end
               else if (restart)
               begin
                  scan_r    <= lrs_pkg::SC_RUN;
                  tickCnt_r <= lrs_pkg::TICK_RST;
                  row_r     <= lrs_pkg::ROW_FIRST;
                  if (master)
                  begin
                     syncTgl_r <= ~syncTgl_r;
                  end
               end
            end
            lrs_pkg::SC_RUN:
            begin
               if (porLvl)
               begin
                  scan_r <= lrs_pkg::SC_HALT;
               end
               else if (master && blankFall)
               begin
                  scan_r <= lrs_pkg::SC_ARM;
               end
               else if (!master && frmEdge)
               begin
                  tickCnt_r <= lrs_pkg::TICK_RST;
                  row_r     <= lrs_pkg::ROW_FIRST;
               end
               else if (tick)
               begin
                  tickCnt_r <= tickCnt_r + 2'h1;
                  if (rowEnd)
                  begin
                     row_r <= row_r + 3'h1;
                     if (master && row_r == 3'h7)
                     begin
                        syncTgl_r <= ~syncTgl_r;
                     end
                  end
               end
            end
            default:
            begin
               scan_r <= lrs_pkg::SC_HALT;
            end
         endcase
      end
   end

   // Mode, sync and light-out flags, kept apart from the row drive
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         staticOff    <= 1'b1;
         panelSyncOut <= 1'b0;
         panelSyncOe  <= 1'b0;
         clockOut     <= 1'b0;
         isMaster     <= 1'b0;
      end
      else if (ce)
      begin
         staticOff    <= porLvl;
         panelSyncOut <= syncTgl_r;
         panelSyncOe  <= master;
         clockOut     <= oscSync_r[1];
         isMaster     <= master;
      end
   end

   // Row drive; RAM read halts while blank is high
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         common_outputs  <= lrs_pkg::COM_RST;
         segment_outputs <= lrs_pkg::SEG_RST;
      end
      else if (ce)
      begin
         if (porLvl || scan_r != lrs_pkg::SC_RUN)
         begin
            common_outputs  <= lrs_pkg::COM_RST;
            segment_outputs <= lrs_pkg::SEG_RST;
         end
         else
         begin
            common_outputs <= rowDecode(row_r);
            if (blankLvl)
            begin
               segment_outputs <= lrs_pkg::SEG_RST;
            end
            else
            begin
               segment_outputs <= ram_r[row_r];
            end
         end
      end
   end

endmodule : lrs_row_scan

/* File: test/lrs_row_scan_properties.sv */
/*
 Checker for the row-scan core, bound to its ports.
 Assumes one clock domain and ticks at least 8 clk apart.
*/
`timescale 1ns/1ps
module lrs_row_scan_properties (
   input wire logic        clk,              // System clock
   input wire logic        srst,             // Sync reset
   input wire logic        oscillator_input, // Display clock pin
   input wire logic        chip_id_bit0,     // Strap 0
   input wire logic        chip_id_bit1,     // Strap 1
   input wire logic        display_blank,    // Blank pin
   input wire logic        porIn,            // Power-on reset pin
   input wire logic        panelSyncOut,     // Sync out
   input wire logic        panelSyncOe,      // Sync enable
   input wire logic        clockOut,         // Clock copy
   input wire logic        isMaster,         // Master flag
   input wire logic [7:0]  common_outputs,   // Commons
   input wire logic [63:0] segment_outputs,  // Segments
   input wire logic        staticOff         // Light-out
);
   logic [2:0] tickCnt_r; // Clock copy rises since commons last moved
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   always_ff @(posedge clk)
   begin
      if (srst)
         tickCnt_r <= 3'h0;
      else if ($changed(common_outputs))
         tickCnt_r <= {2'h0, $rose(clockOut)};
      else if ($rose(clockOut) && tickCnt_r != 3'h7)
         tickCnt_r <= tickCnt_r + 3'h1;
   end
   // Plain step to the next row; restarts and halts land on 0 or 1
   sequence s_advance;
      $changed(common_outputs) && $past(common_outputs) != 8'h00 && common_outputs > 8'h01;
   endsequence
   sequence s_restart;
      ##[1:24] $changed(panelSyncOut);
   endsequence
   a_static_dark: assert property (staticOff |-> common_outputs == 8'h00 && segment_outputs == '0)
      else $error("outputs lit in light-out");
   a_por_holds: assert property (porIn [*8] |-> staticOff)
      else $error("reset pin not holding");
   a_blank_dark: assert property (display_blank [*8] |-> segment_outputs == '0)
      else $error("segments lit while blank");
   a_common_onehot: assert property (common_outputs != 8'h00 |-> $onehot(common_outputs))
      else $error("more than one common");
   a_row_step: assert property (s_advance |-> common_outputs == ($past(common_outputs) << 1))
      else $error("row skipped");
   a_row_ticks: assert property (s_advance |-> tickCnt_r == 3'h4)
      else $error("row not four ticks");
   a_slave_mode: assert property ((chip_id_bit0 || chip_id_bit1) [*8] |-> !isMaster && !panelSyncOe)
      else $error("slave drives sync");
   a_master_mode: assert property ((!chip_id_bit0 && !chip_id_bit1) [*8] |-> isMaster && panelSyncOe)
      else $error("master not driving");
   a_sync_row0: assert property (isMaster && $changed(panelSyncOut) |-> ##[0:2] common_outputs == 8'h01)
      else $error("sync away from row 0");
   a_blank_sync: assert property ($fell(display_blank) && isMaster && !staticOff |-> s_restart)
      else $error("no sync after blank");
   a_por_sync: assert property ($fell(porIn) && isMaster |-> s_restart)
      else $error("no sync after reset pin");
   a_clock_copy: assert property ($past(srst, 4) == 1'b0 |-> clockOut == $past(oscillator_input, 3))
      else $error("clock copy wrong");
endmodule : lrs_row_scan_properties

bind lrs_row_scan lrs_row_scan_properties u_props (.clk, .srst, .oscillator_input,
   .chip_id_bit0, .chip_id_bit1, .display_blank, .porIn, .panelSyncOut, .panelSyncOe,
   .clockOut, .isMaster, .common_outputs, .segment_outputs, .staticOff);

/* File: test/lrs_host_model.sv */
/*
 Host processor model driving the serial link pins.
 Assumes callers enter each task just after a falling clk edge.
*/
`timescale 1ns/1ps
module lrs_host_model (
   input wire logic clk,      // System clock
   output logic     shiftClk, // Shift clock
   output logic     serData,  // Serial data
   output logic     latchIn,  // Latch level
   output logic     wordSel   // Word select
);
   initial
   begin
      {shiftClk, serData, latchIn, wordSel} = 4'hD;
   end
   // 4 clk per level keeps clear of the 3 clk synchroniser delay
   task automatic hold();
      repeat (4) @(negedge clk);
   endtask : hold
   task automatic put_bit(input logic b);
      shiftClk = 1'b0;
      serData = b;
      hold();
      shiftClk = 1'b1;
      hold();
   endtask : put_bit
   task automatic latch_word();
      latchIn = 1'b1;
      hold();
      hold();
      latchIn = 1'b0;
      serData = 1'b1; // Back to its pull-up level between words
      hold();
   endtask : latch_word
   task automatic send_addr(input logic [7:0] a);
      wordSel = 1'b1;
      for (int i = 0; i < 8; i++)
         put_bit(a[i]);
      latch_word();
   endtask : send_addr
   task automatic send_seg(input logic [63:0] s);
      wordSel = 1'b0;
      for (int i = 63; i >= 0; i--)
         put_bit(s[i]);
      latch_word();
   endtask : send_seg
endmodule : lrs_host_model

/* File: test/tb_lrs_row_scan.sv */
/*
 Self-checking bench for the row-scan core with a host model on the serial pins.
 Assumes one chip; the bench plays the master when the core is strapped as slave.
*/
`timescale 1ns/1ps
module tb_lrs_row_scan;
   logic        clk, srst, oscIn, id0, id1, blank, por, slvSync, s;
   logic        sck, sdat, lat, wsel, syncOut, syncOe, clkOut, master, stOff;
   logic [7:0]  com;
   logic [63:0] seg;
   int          errors, cmp_count, n;
   wire logic   syncPin = syncOe ? syncOut : slvSync;
   lrs_host_model host (.clk, .shiftClk(sck), .serData(sdat), .latchIn(lat), .wordSel(wsel));
   lrs_row_scan DUT (.clk, .srst, .ce(1'b1), .oscillator_input(oscIn), .chip_id_bit0(id0),
      .chip_id_bit1(id1), .shiftClk(sck), .serData(sdat), .latchIn(lat), .wordSel(wsel),
      .display_blank(blank), .porIn(por), .panelSyncIn(syncPin), .panelSyncOut(syncOut),
      .panelSyncOe(syncOe), .clockOut(clkOut), .isMaster(master), .common_outputs(com),
      .segment_outputs(seg), .staticOff(stOff));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      oscIn = 1'b0;
      #4;
      forever #16 oscIn = ~oscIn;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic wait_row(input int r);
      n = 0;
      while (com !== (8'h01 << r))
      begin
         @(negedge clk);
         n++;
         if (n > 600)
         begin
            errors++;
            finish_test();
         end
      end
   endtask : wait_row
   function automatic logic [63:0] pat(input int r);
      return 64'hF00D_5A5A_C3C3_8001 ^ {8{r[7:0]}};
   endfunction : pat
   task automatic write_row(input int r, input logic [1:0] id, input logic [63:0] d);
      host.send_addr({2'h2, id, r[2:0], 1'b1});
      host.send_seg(d);
   endtask : write_row
   task automatic t_load();
      for (int r = 0; r < 8; r++)
         write_row(r, 2'h0, pat(r));
      wait_row(3);
      check(seg, '0);
   endtask : t_load
   task automatic t_blank_fall();
      s = syncOut;
      blank = 1'b0;
      wait_row(0);
      check(n <= 24, 1'b1);
      check(syncOut ^ s, 1'b1);
      for (int r = 1; r < 9; r++)
      begin
         wait_row(r % 8);
         check(seg, pat(r % 8));
         if (r == 1)
            check(n, 32);
      end
      check(syncOut, s);
   endtask : t_blank_fall
   task automatic t_wrong_id();
      write_row(4, 2'h1, '0);
      wait_row(4);
      check(seg, pat(4));
      wait_row(7);
      check(seg, pat(7));
   endtask : t_wrong_id
   task automatic t_por_ignore();
      por = 1'b1;
      write_row(5, 2'h0, '1);
      check(stOff, 1'b1);
      check(com, 8'h00);
      por = 1'b0;
      wait_row(5);
      check(seg, pat(5));
   endtask : t_por_ignore
   task automatic t_reset();
      repeat (8) @(negedge clk);
      check({stOff, com}, 9'h100);
      por = 1'b0;
   endtask : t_reset
   task automatic t_slave();
      wait_row(2);
      slvSync = syncOut;
      for (int i = 3; i > 0; i--)
      begin
         {id1, id0} = 2'(i);
         repeat (10) @(negedge clk);
         check({master, syncOe}, 2'h0);
      end
      slvSync = ~slvSync;
      wait_row(0);
      check(n <= 8, 1'b1);
      {id1, id0} = 2'h0;
      repeat (10) @(negedge clk);
      check({master, syncOe}, 2'h3);
   endtask : t_slave
   initial
   begin
      {srst, por, blank, id0, id1, slvSync} = 6'h38;
      {errors, cmp_count} = '0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_load();
      t_blank_fall();
      t_wrong_id();
      t_por_ignore();
      t_slave();
      finish_test();
   end
endmodule : tb_lrs_row_scan
